// File: inc/sps_map.vh
// Register map and timing constants of the spindle power sequencer
`ifndef SPS_MAP_VH
`define SPS_MAP_VH
`define SPS_ADDR_W 12
`define SPS_CTRL_OFF 12'h000
`define SPS_STAT_OFF 12'h004
`define SPS_CTRL_START 0
`define SPS_CTRL_REMOTE 1
`define SPS_CTRL_ADDR_LSB 4
`define SPS_CTRL_ADDR_MSB 7
`define SPS_CTRL_RST 32'h00000000
`define SPS_CTRL_WMASK 32'h000000f2
`define SPS_CLK_HZ 32'h02625a00
`define SPS_STEP_S 5
`define SPS_UP_LIMIT_S 90
`define SPS_DOWN_LIMIT_S 60
`define SPS_FAST_MS 100
`define SPS_SLOW_MS 500
`define SPS_SPIN_MS 2000
`define SPS_CNT_W 32
`endif

// File: hw/sps_sequencer.v
// Spindle power sequencer with APB registers and Ready lamp
`timescale 1ns/10ps
`default_nettype none
`include "sps_map.vh"

module sps_sequencer #(
    parameter [31:0] STEP_CYC = `SPS_STEP_S * `SPS_CLK_HZ,
    parameter [31:0] UP_LIMIT_CYC = `SPS_UP_LIMIT_S * `SPS_CLK_HZ,
    parameter [31:0] DOWN_LIMIT_CYC = `SPS_DOWN_LIMIT_S * `SPS_CLK_HZ,
    parameter [31:0] FAST_HALF_CYC = `SPS_FAST_MS * (`SPS_CLK_HZ / 1000),
    parameter [31:0] SLOW_HALF_CYC = `SPS_SLOW_MS * (`SPS_CLK_HZ / 1000)
)
(
    // Clock and reset
    input wire i_mclk,
    input wire i_reset_n,
    input wire i_ce,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [`SPS_ADDR_W-1:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire o_pready,
    output wire o_pslverr,
    output reg [31:0] o_prdata,
    // Front panel and controller pins
    input wire i_start_btn,
    input wire i_seq_hold_n,
    // Spindle mechanics
    input wire i_at_speed,
    input wire i_heads_loaded,
    input wire i_heads_parked,
    input wire i_spindle_stopped,
    output reg o_spin_en,
    output reg o_heads_load,
    // Status outputs
    output reg o_ready_lamp,
    output reg o_fault,
    output reg o_drive_ready
);

localparam [4:0] ST_STOP = 5'h01;
localparam [4:0] ST_DELAY = 5'h02;
localparam [4:0] ST_UP = 5'h04;
localparam [4:0] ST_READY = 5'h08;
localparam [4:0] ST_DOWN = 5'h10;

reg [4:0] state_q;
reg [31:0] ctrl_q;
reg [31:0] cnt_q;
reg [31:0] lim_q;
reg [31:0] flash_q;
reg flash_ph_q;
reg btn_dly_q;
reg sw_start_q;
wire btn_lvl;
wire hold_lvl;
wire spd_lvl;
wire ld_lvl;
wire prk_lvl;
wire stp_lvl;

wire remote = ctrl_q[`SPS_CTRL_REMOTE];
wire [3:0] log_addr = ctrl_q[`SPS_CTRL_ADDR_MSB:`SPS_CTRL_ADDR_LSB];
wire btn_press = btn_lvl & ~btn_dly_q;
wire hold_on = ~hold_lvl;
wire start_req = btn_press | sw_start_q;
wire [35:0] delay_full = STEP_CYC * log_addr;
wire [31:0] delay_cyc = delay_full[31:0];
wire wr_en = i_psel & i_penable & i_pwrite;
wire rd_hit_ctrl = i_paddr == `SPS_CTRL_OFF;
wire rd_hit_stat = i_paddr == `SPS_STAT_OFF;

assign o_pready = 1'b1;
assign o_pslverr = i_psel & i_penable & ~rd_hit_ctrl & ~rd_hit_stat;

// Pin synchronisers
sps_sync2 #(
    .RST_VAL(1'b0)
) btn_sync_inst (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_pin(i_start_btn),
    .o_level(btn_lvl)
);
sps_sync2 #(
    .RST_VAL(1'b1)
) hold_sync_inst (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_pin(i_seq_hold_n),
    .o_level(hold_lvl)
);
sps_sync2 #(
    .RST_VAL(1'b0)
) spd_sync_inst (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_pin(i_at_speed),
    .o_level(spd_lvl)
);
sps_sync2 #(
    .RST_VAL(1'b0)
) ld_sync_inst (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_pin(i_heads_loaded),
    .o_level(ld_lvl)
);
sps_sync2 #(
    .RST_VAL(1'b0)
) prk_sync_inst (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_pin(i_heads_parked),
    .o_level(prk_lvl)
);
sps_sync2 #(
    .RST_VAL(1'b0)
) stp_sync_inst (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_pin(i_spindle_stopped),
    .o_level(stp_lvl)
);

// Button edge detector
always @(posedge i_mclk or negedge i_reset_n)
begin
    if (!i_reset_n)
        btn_dly_q <= 1'b0;
    else if (i_ce)
        btn_dly_q <= btn_lvl;
end

// Register writes and read data
always @(posedge i_mclk or negedge i_reset_n)
begin
    if (!i_reset_n)
    begin
        ctrl_q <= `SPS_CTRL_RST;
        sw_start_q <= 1'b0;
        o_prdata <= 32'h00000000;
    end
    else if (i_ce)
    begin
        sw_start_q <= 1'b0;
        if (wr_en && rd_hit_ctrl)
        begin
            ctrl_q <= i_pwdata & `SPS_CTRL_WMASK;
            sw_start_q <= i_pwdata[`SPS_CTRL_START];
        end
        if (i_psel && !i_penable)
        begin
            if (rd_hit_ctrl)
                o_prdata <= ctrl_q;
            else if (rd_hit_stat)
                o_prdata <= {24'h000000, hold_on, o_fault, o_ready_lamp,
                    state_q};
            else
                o_prdata <= 32'h00000000;
        end
    end
end

// Sequencer
always @(posedge i_mclk or negedge i_reset_n)
begin
    if (!i_reset_n)
    begin
        state_q <= ST_STOP;
        cnt_q <= 32'h00000000;
        lim_q <= 32'h00000000;
        o_spin_en <= 1'b0;
        o_heads_load <= 1'b0;
        o_fault <= 1'b0;
        o_drive_ready <= 1'b0;
    end
    else if (i_ce)
    begin
        if (state_q != ST_STOP && state_q != ST_READY)
            lim_q <= lim_q + 32'h00000001;
        case (state_q)
            ST_STOP:
            begin
                o_spin_en <= 1'b0;
                o_heads_load <= 1'b0;
                o_drive_ready <= 1'b0;
                if (remote ? hold_on : start_req)
                begin
                    o_fault <= 1'b0;
                    cnt_q <= 32'h00000000;
                    lim_q <= 32'h00000000;
                    state_q <= remote ? ST_DELAY : ST_UP;
                end
            end
            ST_DELAY:
            begin
                if (!hold_on)
                    state_q <= ST_STOP;
                else if (cnt_q >= delay_cyc)
                begin
                    lim_q <= 32'h00000000;
                    state_q <= ST_UP;
                end
                else
                    cnt_q <= cnt_q + 32'h00000001;
            end
            ST_UP:
            begin
                o_spin_en <= 1'b1;
                o_heads_load <= spd_lvl;
                if (remote && !hold_on)
                begin
                    lim_q <= 32'h00000000;
                    state_q <= ST_DOWN;
                end
                else if (spd_lvl && ld_lvl)
                begin
                    o_drive_ready <= 1'b1;
                    state_q <= ST_READY;
                end
                else if (lim_q >= UP_LIMIT_CYC)
                    o_fault <= 1'b1;
            end
            ST_READY:
            begin
                if (remote ? !hold_on : start_req)
                begin
                    o_drive_ready <= 1'b0;
                    lim_q <= 32'h00000000;
                    state_q <= ST_DOWN;
                end
            end
            ST_DOWN:
            begin
                o_heads_load <= 1'b0;
                if (prk_lvl)
                    o_spin_en <= 1'b0;
                if (prk_lvl && stp_lvl && !o_spin_en)
                    state_q <= ST_STOP;
                else if (lim_q >= DOWN_LIMIT_CYC)
                    o_fault <= 1'b1;
            end
            default:
                state_q <= ST_STOP;
        endcase
    end
end

// Ready lamp flash generator
always @(posedge i_mclk or negedge i_reset_n)
begin
    if (!i_reset_n)
    begin
        flash_q <= 32'h00000000;
        flash_ph_q <= 1'b0;
        o_ready_lamp <= 1'b0;
    end
    else if (i_ce)
    begin
        if ((state_q == ST_UP && flash_q >= FAST_HALF_CYC - 32'h1) ||
            (state_q == ST_DOWN && flash_q >= SLOW_HALF_CYC - 32'h1))
        begin
            flash_q <= 32'h00000000;
            flash_ph_q <= ~flash_ph_q;
        end
        else if (state_q == ST_UP || state_q == ST_DOWN)
            flash_q <= flash_q + 32'h00000001;
        else
        begin
            flash_q <= 32'h00000000;
            flash_ph_q <= 1'b0;
        end
        case (state_q)
            ST_UP: o_ready_lamp <= ~flash_ph_q;
            ST_DOWN: o_ready_lamp <= ~flash_ph_q;
            ST_READY: o_ready_lamp <= 1'b1;
            default: o_ready_lamp <= 1'b0;
        endcase
    end
end

endmodule // sps_sequencer

// Two-flop synchroniser for one asynchronous pin
module sps_sync2 #(
    parameter [0:0] RST_VAL = 1'b0
)
(
    // Clock and reset
    input wire i_mclk,
    input wire i_reset_n,
    input wire i_ce,
    // Pin in, level out
    input wire i_pin,
    output wire o_level
);

reg [1:0] sync_q;

assign o_level = sync_q[1];

always @(posedge i_mclk or negedge i_reset_n)
begin
    if (!i_reset_n)
        sync_q <= {2{RST_VAL}};
    else if (i_ce)
        sync_q <= {sync_q[0], i_pin};
end

endmodule // sps_sync2
`default_nettype wire

// File: tb/sps_chk.sv
// Assertion checker of the spindle power sequencer
`timescale 1ns/10ps
`default_nettype none
module sps_chk #(
    parameter int FAST_HALF_CYC = 4,
    parameter int SLOW_HALF_CYC = 16
)
(
    // Clock and bus
    input wire i_mclk,
    input wire i_reset_n,
    input wire i_ce,
    input wire i_psel,
    input wire i_penable,
    input wire [11:0] i_paddr,
    input wire o_pready,
    input wire o_pslverr,
    input wire [31:0] o_prdata,
    // Spindle and lamp
    input wire o_spin_en,
    input wire o_heads_load,
    input wire o_ready_lamp,
    input wire o_drive_ready
);
default clocking cb @(posedge i_mclk); endclocking
default disable iff (!i_reset_n);
rdy_const_a: assert property (o_pready) else $error("pready low");
err_map_a: assert property (o_pslverr == (i_psel && i_penable &&
    i_paddr != 12'h000 && i_paddr != 12'h004)) else $error("slverr");
err_zero_a: assert property (o_pslverr |-> o_prdata == 32'h0)
    else $error("refused read data");
lamp_ready_a: assert property (o_drive_ready && $past(o_drive_ready) |->
    o_ready_lamp) else $error("lamp not steady");
ready_spin_a: assert property (o_drive_ready |-> o_spin_en &&
    o_heads_load) else $error("ready idle");
fast_half_a: assert property ($rose(o_ready_lamp) && o_spin_en &&
    !o_drive_ready |-> ##FAST_HALF_CYC (!o_ready_lamp || o_drive_ready))
    else $error("fast flash");
slow_half_a: assert property ($rose(o_ready_lamp) && !o_spin_en |->
    ##SLOW_HALF_CYC !o_ready_lamp) else $error("slow flash");
park_first_a: assert property ($fell(o_spin_en) |-> !o_heads_load)
    else $error("heads not parked");
ce_freeze_a: assert property (!i_ce |=> $stable(o_ready_lamp) &&
    $stable(o_spin_en) && $stable(o_drive_ready)) else $error("ce");
endmodule // sps_chk
bind sps_sequencer sps_chk #(.FAST_HALF_CYC(FAST_HALF_CYC),
    .SLOW_HALF_CYC(SLOW_HALF_CYC)) sps_chk_inst (.i_mclk(i_mclk),
    .i_reset_n(i_reset_n), .i_ce(i_ce), .i_psel(i_psel),
    .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_prdata(o_prdata), .o_spin_en(o_spin_en),
    .o_heads_load(o_heads_load), .o_ready_lamp(o_ready_lamp),
    .o_drive_ready(o_drive_ready));
`default_nettype wire

// File: tb/sps_host_model.sv
// Host controller sequence level and spindle mechanics model
`timescale 1ns/10ps
`default_nettype none
module sps_host_model (
    input wire logic i_mclk,
    input wire logic i_engage,
    input wire logic [7:0] i_lag,
    input wire logic i_spin_en,
    input wire logic i_heads_load,
    output logic o_seq_hold_n = 1'b1,
    output logic o_at_speed = 1'b0,
    output logic o_heads_loaded = 1'b0,
    output logic o_heads_parked = 1'b1,
    output logic o_spindle_stopped = 1'b1
);
logic [7:0] up_q = 8'h00;
logic [7:0] dn_q = 8'h00;
always @(posedge i_mclk)
begin
    o_seq_hold_n <= !i_engage;
    up_q <= !i_spin_en ? 8'h00 : (up_q == 8'hff ? up_q : up_q + 8'h01);
    dn_q <= i_spin_en ? 8'h00 : (dn_q == 8'hff ? dn_q : dn_q + 8'h01);
    o_at_speed <= i_spin_en && up_q >= i_lag;
    o_heads_loaded <= i_heads_load && o_at_speed;
    o_heads_parked <= !i_heads_load;
    o_spindle_stopped <= !i_spin_en && dn_q >= 8'h10;
end
endmodule // sps_host_model
`default_nettype wire

// File: tb/sps_sequencer_tb.sv
// Testbench of the spindle power sequencer
`timescale 1ns/10ps
`default_nettype none
`include "sps_map.vh"
module sps_sequencer_tb;
logic clk = 0, rst_n = 0, ce = 1, sel = 0, en = 0, wr = 0, btn = 0;
logic eng = 0, rdy, err, re, sq, at, hl, hp, ss, sp, ld, lamp, flt, dr;
logic [11:0] adr = 0;
logic [31:0] wd = 0, rd, prd;
logic [7:0] lag = 8'h28;
int n_errors = 0, n_compared = 0, cyc = 0;
initial forever #12.5 clk = ~clk;
sps_sequencer #(.STEP_CYC(20), .UP_LIMIT_CYC(200), .DOWN_LIMIT_CYC(200),
    .FAST_HALF_CYC(4), .SLOW_HALF_CYC(8)) sps_sequencer_inst (
    .i_mclk(clk), .i_reset_n(rst_n), .i_ce(ce), .i_psel(sel),
    .i_penable(en), .i_pwrite(wr), .i_paddr(adr), .i_pwdata(wd),
    .o_pready(rdy), .o_pslverr(err), .o_prdata(prd), .i_start_btn(btn),
    .i_seq_hold_n(sq), .i_at_speed(at), .i_heads_loaded(hl),
    .i_heads_parked(hp), .i_spindle_stopped(ss), .o_spin_en(sp),
    .o_heads_load(ld), .o_ready_lamp(lamp), .o_fault(flt),
    .o_drive_ready(dr));
sps_host_model sps_host_model_inst (.i_mclk(clk), .i_engage(eng),
    .i_lag(lag), .i_spin_en(sp), .i_heads_load(ld), .o_seq_hold_n(sq),
    .o_at_speed(at), .o_heads_loaded(hl), .o_heads_parked(hp),
    .o_spindle_stopped(ss));
task report_and_stop;
    if (n_errors == 0 && n_compared > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
task chk(input [31:0] seen, input [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
        n_errors++;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task apb(input w, input [11:0] a, input [31:0] d);
    sel <= 1;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    en <= 1;
    @(posedge clk);
    while (rdy !== 1'b1)
        @(posedge clk);
    rd = prd;
    re = err;
    sel <= 0;
    en <= 0;
    @(posedge clk);
endtask
task wait_st(input [4:0] s);
    int i;
    i = 0;
    do
    begin
        apb(0, `SPS_STAT_OFF, 0);
        i++;
    end
    while (rd[4:0] !== s && i < 400);
    chk(rd[4:0], s);
endtask
task press;
    btn <= 1;
    repeat (6) @(posedge clk);
    btn <= 0;
    repeat (6) @(posedge clk);
endtask
always @(posedge clk)
begin
    cyc++;
    if (cyc == 20000)
    begin
        n_errors++;
        report_and_stop;
    end
end
initial
begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, `SPS_STAT_OFF, 0);
    chk(rd, 32'h1);
    apb(0, `SPS_CTRL_OFF, 0);
    chk(rd, `SPS_CTRL_RST);
    apb(1, 12'h008, 32'hff);
    chk(re, 1);
    apb(0, 12'h008, 0);
    chk(re, 1);
    chk(rd, 0);
    apb(0, `SPS_CTRL_OFF, 0);
    chk(rd, `SPS_CTRL_RST);
    apb(1, `SPS_CTRL_OFF, 32'h1);
    wait_st(5'h04);
    press;
    wait_st(5'h08);
    apb(0, `SPS_STAT_OFF, 0);
    chk(rd[7:0], 8'h28);
    chk({sp, ld, dr}, 3'h7);
    press;
    wait_st(5'h10);
    wait_st(5'h01);
    chk(rd, 32'h1);
    chk({sp, ld, dr}, 3'h0);
    ce <= 0;
    repeat (3) @(posedge clk);
    ce <= 1;
    apb(1, `SPS_CTRL_OFF, 32'h33);
    apb(0, `SPS_CTRL_OFF, 0);
    chk(rd, 32'h32);
    eng <= 1;
    wait_st(5'h02);
    repeat (45) @(posedge clk);
    apb(0, `SPS_STAT_OFF, 0);
    chk(rd[4:0], 5'h02);
    wait_st(5'h04);
    wait_st(5'h08);
    press;
    apb(0, `SPS_STAT_OFF, 0);
    chk(rd[4:0], 5'h08);
    eng <= 0;
    wait_st(5'h10);
    wait_st(5'h01);
    lag <= 8'hfa;
    apb(1, `SPS_CTRL_OFF, 32'h02);
    eng <= 1;
    repeat (6) @(posedge clk);
    apb(0, `SPS_STAT_OFF, 0);
    chk(rd[4:0], 5'h04);
    wait_st(5'h08);
    chk(flt, 1);
    eng <= 0;
    wait_st(5'h01);
    report_and_stop;
end
endmodule // sps_sequencer_tb
`default_nettype wire
